// ---- hw/rbc_reset_brownout_control.v ----
/*
  Reset and brown-out control: filters the reset pin and the stop-level
  indication, sequences internal reset, stability wait and initialisation,
  gates the brown-out detector and records reset sources. Registers sit on
  an Avalon-MM slave with waitrequest. rst_n is the power-on reset; every
  other source resets the rest of the chip through systemResetN only.
  Every source, power-on and brown-out included, runs the full stability
  wait before the five initialisation clocks.
  All inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rbc_consts.vh"

module rbc_reset_brownout_control #(
  parameter [`RBC_CNT_W-1:0] STABLE_CYCLES = `RBC_STABLE_CYC
) (
  // Clock and power-on reset
  input  wire                   clk,
  input  wire                   rst_n,
  // Avalon-MM slave
  input  wire [`RBC_ADDR_W-1:0] avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [3:0]             avs_byteenable,
  input  wire [31:0]            avs_writedata,
  output reg  [31:0]            avs_readdata,
  output reg                    avs_waitrequest,
  // Reset sources
  input  wire                   externalResetPinN,
  input  wire                   watchdogReset,
  input  wire                   debuggerReset,
  // Power management
  input  wire                   stopModeRequest,
  // Analog comparator outputs, high when supply is below the level
  input  wire                   stopLevelIndication,
  input  wire                   warnLevelOne,
  input  wire                   warnLevelTwo,
  input  wire                   warnLevelThree,
  input  wire                   warnLevelFour,
  // To the detector and the rest of the chip
  output reg                    detectorActive,
  output reg                    systemResetN,
  output reg                    initActive,
  output reg                    fetchEnable,
  output reg  [15:0]            fetchAddress,
  output reg                    brownoutMode
);

  localparam [`RBC_CNT_W-1:0] PIN_CYC  = `RBC_PIN_FILTER_CYC;
  localparam [`RBC_CNT_W-1:0] STOP_CYC = `RBC_STOP_FILTER_CYC;
  localparam [`RBC_CNT_W-1:0] INIT_CYC = `RBC_INIT_CYC;

  // Sequencer states
  localparam [2:0] ST_RUN      = 3'h0;
  localparam [2:0] ST_HOLD     = 3'h1;
  localparam [2:0] ST_STABLE   = 3'h2;
  localparam [2:0] ST_INIT     = 3'h3;
  localparam [2:0] ST_BROWNOUT = 3'h4;

  // Register address decode, shared by read and write paths
  function hitIndex;
    input [`RBC_ADDR_W-1:0] addr;
    input [7:0]             index;
    begin
      hitIndex = (addr == {index, 2'b00});
    end
  endfunction

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg         detectorEnable;
  reg  [3:0]  warnLevels;
  wire        pinLowLong;
  wire        stopLevelFiltered;
  wire        stableDone;
  wire        initDone;
  wire        flagPowerOn;
  wire        flagPin;
  wire        flagWatchdog;
  wire        flagDebugger;
  wire        flagUndervolt;
  wire [7:0]  ctrlFlags;
  wire [7:0]  warnStatus;
  wire        busWrite;
  wire        ctrlWrite;
  wire        lowByteOn;
  reg         setPin;
  reg         setWatchdog;
  reg         setDebugger;
  reg         setUndervolt;

  // Reset pin noise canceller: a short low pulse never reaches the sequencer
  rbc_run_counter #(
    .LIMIT (PIN_CYC)
  ) pinFilter (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (~externalResetPinN),
    .reached (pinLowLong)
  );

  // Stop-level noise canceller; comparator is ignored while detector is off
  rbc_run_counter #(
    .LIMIT (STOP_CYC)
  ) stopFilter (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (stopLevelIndication & detectorActive),
    .reached (stopLevelFiltered)
  );

  // Stability interval after the reset source goes away
  rbc_run_counter #(
    .LIMIT (STABLE_CYCLES)
  ) stableTimer (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (state == ST_STABLE),
    .reached (stableDone)
  );

  // Initialisation interval after internal reset release; the state moves one
  // clock after reached rises, so one less gives exactly five clocks in INIT
  rbc_run_counter #(
    .LIMIT (INIT_CYC - 24'h000001)
  ) initTimer (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (state == ST_INIT),
    .reached (initDone)
  );

  // Sequencer next state
  always @* begin
    next_state   = state;
    setPin       = 1'b0;
    setWatchdog  = 1'b0;
    setDebugger  = 1'b0;
    setUndervolt = 1'b0;
    case (state)
      ST_RUN: begin
        if (pinLowLong) begin
          next_state = ST_HOLD;
          setPin     = 1'b1;
        end else if (watchdogReset) begin
          next_state  = ST_HOLD;
          setWatchdog = 1'b1;
        end else if (debuggerReset) begin
          next_state  = ST_HOLD;
          setDebugger = 1'b1;
        end else if (stopLevelFiltered) begin
          next_state = ST_BROWNOUT;
        end
      end
      ST_HOLD: begin
        if (!pinLowLong) begin
          next_state = ST_STABLE;
        end
      end
      ST_STABLE, ST_INIT: begin
        if (pinLowLong) begin
          next_state = ST_HOLD;
          setPin     = 1'b1;
        end else if (state == ST_STABLE && stableDone) begin
          next_state = ST_INIT;
        end else if (state == ST_INIT && initDone) begin
          next_state = ST_RUN;
        end
      end
      ST_BROWNOUT: begin
        // A supply rise, or a write clearing the detector enable bit, ends brown-out mode
        if (!stopLevelFiltered) begin
          next_state   = ST_HOLD;
          setUndervolt = 1'b1;
        end
      end
      default: begin
        // An illegal code falls back to a held reset, never to run
        next_state = ST_HOLD;
      end
    endcase
  end

  // Power-on starts in the stability wait, as a released pin would
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_STABLE;
    end else begin
      state <= next_state;
    end
  end

  // Chip-facing outputs, all registered from the next state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      systemResetN <= 1'b0;
      initActive   <= 1'b0;
      fetchEnable  <= 1'b0;
      fetchAddress <= `RBC_RESET_VECTOR;
      brownoutMode <= 1'b0;
    end else begin
      systemResetN <= (next_state == ST_INIT) || (next_state == ST_RUN) ||
                      (next_state == ST_BROWNOUT);
      initActive   <= (next_state == ST_INIT);
      fetchEnable  <= (next_state == ST_RUN);
      brownoutMode <= (next_state == ST_BROWNOUT);
      if (next_state == ST_INIT) begin
        fetchAddress <= `RBC_RESET_VECTOR;
      end
    end
  end

  // Detector power: enable bit, minus software stop; brown-out keeps it on
  // Trade-off: a drop during software stop goes unseen until stop ends
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detectorActive <= 1'b1;
    end else begin
      detectorActive <= detectorEnable &&
                        (!stopModeRequest || next_state == ST_BROWNOUT);
    end
  end

  // Warning comparators sampled for software; no interrupt path exists
  // One flop of delay; the comparator levels are taken as synchronous
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warnLevels <= 4'h0;
    end else begin
      warnLevels <= {warnLevelFour, warnLevelThree, warnLevelTwo, warnLevelOne};
    end
  end

  // Write takes effect on the edge where waitrequest is seen low
  assign busWrite  = avs_write && !avs_waitrequest;
  assign lowByteOn = avs_byteenable[0];
  assign ctrlWrite = busWrite && lowByteOn && hitIndex(avs_address, `RBC_IDX_CTRL_FLAGS);

  // Detector enable bit; only power-on reset restores it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detectorEnable <= 1'b1;
    end else if (ctrlWrite) begin
      detectorEnable <= avs_writedata[`RBC_BIT_DET_ENABLE];
    end
  end

  // Reset-source flags; writing 1 leaves a flag alone
  rbc_sticky_flag #(
    .RESET_VALUE (1'b1)
  ) powerOnFlag (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (1'b0),
    .clear (ctrlWrite && !avs_writedata[`RBC_BIT_POWER_ON]),
    .flag  (flagPowerOn)
  );

  // Pin, watchdog and debugger flags set as the sequencer enters hold
  rbc_sticky_flag #(
    .RESET_VALUE (1'b0)
  ) pinFlag (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (setPin),
    .clear (ctrlWrite && !avs_writedata[`RBC_BIT_PIN]),
    .flag  (flagPin)
  );

  rbc_sticky_flag #(
    .RESET_VALUE (1'b0)
  ) watchdogFlag (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (setWatchdog),
    .clear (ctrlWrite && !avs_writedata[`RBC_BIT_WATCHDOG]),
    .flag  (flagWatchdog)
  );

  rbc_sticky_flag #(
    .RESET_VALUE (1'b0)
  ) debuggerFlag (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (setDebugger),
    .clear (ctrlWrite && !avs_writedata[`RBC_BIT_DEBUGGER]),
    .flag  (flagDebugger)
  );

  // Brown-out flag is set on the way out of brown-out mode
  rbc_sticky_flag #(
    .RESET_VALUE (1'b0)
  ) undervoltFlag (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (setUndervolt),
    .clear (ctrlWrite && !avs_writedata[`RBC_BIT_UNDERVOLT]),
    .flag  (flagUndervolt)
  );

  // Register images; unused bits read zero
  assign ctrlFlags  = {flagPowerOn, flagPin, flagWatchdog, flagDebugger,
                       flagUndervolt, 2'b00, detectorEnable};
  assign warnStatus = {4'h0, warnLevels};

  // Bus handshake: one wait cycle, then a single low cycle of waitrequest.
  // The extra cycle keeps readdata a flop output at a fixed latency.
  // Unmapped addresses are answered too, reading zero, so no access can hang.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      if (avs_read && hitIndex(avs_address, `RBC_IDX_CTRL_FLAGS)) begin
        avs_readdata <= {24'h000000, ctrlFlags};
      end else if (avs_read && hitIndex(avs_address, `RBC_IDX_WARN_STATUS)) begin
        avs_readdata <= {24'h000000, warnStatus};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ---- hw/rbc_consts.vh ----
/*
  Constants of the reset and brown-out control block: register indices,
  field positions, reset values and timing counts.
  Assumes a 20 MHz main clock; the control block and the run counter include it.
*/
`ifndef RBC_CONSTS_VH
`define RBC_CONSTS_VH

// Clock
`define RBC_CLK_PERIOD_NS   50
`define RBC_CLK_MHZ         20

// Register indices; byte address is four times the index
`define RBC_IDX_CTRL_FLAGS  8'h86
`define RBC_IDX_WARN_STATUS 8'h8F
`define RBC_ADDR_W          10

// Control and reset-flag register fields
`define RBC_BIT_POWER_ON    7
`define RBC_BIT_PIN         6
`define RBC_BIT_WATCHDOG    5
`define RBC_BIT_DEBUGGER    4
`define RBC_BIT_UNDERVOLT   3
`define RBC_BIT_DET_ENABLE  0
`define RBC_CTRL_RESET      8'h81
`define RBC_WARN_RESET      8'h00

// Timing: figures as given; cycle counts at 50 ns a clock, sized to the counter
`define RBC_PIN_FILTER_NS   8000
`define RBC_STOP_FILTER_NS  7000
`define RBC_STABLE_US       64000
`define RBC_PIN_FILTER_CYC  24'h0000A0
`define RBC_STOP_FILTER_CYC 24'h00008C
`define RBC_STABLE_CYC      24'h138800
`define RBC_INIT_CYC        24'h000005
`define RBC_CNT_W           24

// Reset vector
`define RBC_RESET_VECTOR    16'h0000

`endif

// ---- hw/rbc_run_counter.v ----
/*
  Run-length counter: output rises once the input has been high for LIMIT
  consecutive clocks and falls at once when the input drops.
  Serves as noise filter and as interval timer. Input is synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rbc_consts.vh"

module rbc_run_counter #(
  parameter [`RBC_CNT_W-1:0] LIMIT = 24'h000001
) (
  // Clock and reset
  input  wire                  clk,
  input  wire                  rst_n,
  // Level to measure
  input  wire                  run,
  // High once run has lasted LIMIT cycles
  output reg                   reached
);

  reg  [`RBC_CNT_W-1:0] count;

  // Count saturates at LIMIT so a long level cannot wrap around
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= 24'h000000;
      reached <= 1'b0;
    end else if (!run) begin
      count   <= 24'h000000;
      reached <= 1'b0;
    end else if (count < LIMIT) begin
      count   <= count + 24'h000001;
      reached <= (count == LIMIT - 24'h000001);
    end
  end

endmodule
`default_nettype wire

// ---- hw/rbc_sticky_flag.v ----
/*
  One sticky event flag: set by hardware, cleared by software.
  Assumes set and clear are single-cycle and synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module rbc_sticky_flag #(
  parameter RESET_VALUE = 1'b0
) (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Event and software clear
  input  wire set,
  input  wire clear,
  // Stored flag
  output reg  flag
);

  // Set wins over a clear in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= RESET_VALUE;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- sim/rbc_checker.sv ----
/*
  Port checker for the reset and brown-out control block.
  Assumes one clock domain and binding onto rbc_reset_brownout_control.
*/
`timescale 1ns/1ps
`default_nettype none

module rbc_checker #(
  parameter int STABLE_CYCLES = 20
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Sources
  input wire logic        externalResetPinN,
  input wire logic        stopModeRequest,
  input wire logic        stopLevelIndication,
  // Outputs watched
  input wire logic        detectorActive,
  input wire logic        systemResetN,
  input wire logic        initActive,
  input wire logic        fetchEnable,
  input wire logic [15:0] fetchAddress,
  input wire logic        brownoutMode
);
  int stopRun;
  int lowRun;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Run lengths; counters stand in for repetitions far too long to unroll
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stopRun <= 0;
      lowRun  <= 0;
    end else begin
      stopRun <= stopLevelIndication ? stopRun + 1 : 0;
      lowRun  <= (!systemResetN && externalResetPinN) ? lowRun + 1 : 0;
    end
  end

  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing wrong");
  AST_UPPER_ZERO: assert property (!avs_waitrequest && $past(avs_read)
    |-> avs_readdata[31:8] == 24'h000000) else $error("upper read bits not zero");
  AST_STABLE_TIME: assert property ($rose(systemResetN)
    |-> lowRun >= STABLE_CYCLES && lowRun <= STABLE_CYCLES + 3)
    else $error("stability interval wrong");
  AST_INIT_LEN: assert property ($rose(initActive)
    |-> initActive[*5] ##1 !initActive) else $error("init length wrong");
  AST_INIT_START: assert property ($rose(initActive) |-> systemResetN && !fetchEnable)
    else $error("init overlaps reset or fetch");
  AST_FETCH_VECTOR: assert property ($rose(fetchEnable)
    |-> $past(initActive) && fetchAddress == 16'h0000) else $error("fetch start wrong");
  AST_FETCH_GATE: assert property (fetchEnable
    |-> systemResetN && !initActive && !brownoutMode) else $error("fetch while held");
  AST_BO_ENTRY: assert property ($rose(brownoutMode)
    |-> systemResetN && $past(detectorActive) && stopRun >= 139)
    else $error("brown-out entry wrong");
  AST_BO_DETECTOR: assert property (brownoutMode |-> detectorActive)
    else $error("detector off in brown-out mode");
  AST_BO_EXIT: assert property ($fell(brownoutMode)
    |-> !stopLevelIndication ##[0:1] !systemResetN) else $error("brown-out exit wrong");
  AST_STOP_MODE: assert property ((stopModeRequest && !brownoutMode)[*3]
    |-> !detectorActive) else $error("detector on in stop mode");

  COV_BROWNOUT: cover property ($rose(brownoutMode));
  COV_INIT: cover property ($rose(initActive));
  COV_WRITE: cover property (avs_write && !avs_waitrequest);
endmodule

bind rbc_reset_brownout_control rbc_checker #(.STABLE_CYCLES(STABLE_CYCLES)) chk (
  .clk, .rst_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .externalResetPinN, .stopModeRequest, .stopLevelIndication, .detectorActive,
  .systemResetN, .initActive, .fetchEnable, .fetchAddress, .brownoutMode);

`default_nettype wire

// ---- sim/rbc_partner.sv ----
/*
  Model of the reset pin driver and the supply comparators.
  Assumes the caller invokes its tasks; each drives just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module rbc_partner (
  // Clock
  input  wire logic       clk,
  // Pin and comparator levels
  output var  logic       externalResetPinN,
  output var  logic       stopLevelIndication,
  output var  logic [3:0] warnLevels
);
  // Supply healthy, pin released
  initial begin
    externalResetPinN = 1'b1;
    stopLevelIndication = 1'b0;
    warnLevels = 4'h0;
  end

  // Pin low for n clocks; 160 or more makes a real reset
  task automatic pulsePin(input int n);
    @(posedge clk);
    externalResetPinN <= 1'b0;
    repeat (n) @(posedge clk);
    externalResetPinN <= 1'b1;
  endtask

  // Supply under the stop level for n clocks
  task automatic pulseStop(input int n);
    @(posedge clk);
    stopLevelIndication <= 1'b1;
    repeat (n) @(posedge clk);
    stopLevelIndication <= 1'b0;
  endtask

  // Warning comparators, one bit per level
  task automatic setWarn(input logic [3:0] w);
    @(posedge clk);
    warnLevels <= w;
  endtask
endmodule

`default_nettype wire

// ---- sim/test_reset_brownout_control.sv ----
/*
  Self-checking bench for the reset and brown-out control block.
  Assumes rbc_partner and the bound checker; stability wait cut to 20 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module test_reset_brownout_control;
  logic        clk;
  logic        rst_n;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        watchdogReset;
  logic        debuggerReset;
  logic        stopModeRequest;
  logic        externalResetPinN;
  logic        stopLevelIndication;
  logic [3:0]  warnLevels;
  logic        detectorActive;
  logic        systemResetN;
  logic        initActive;
  logic        fetchEnable;
  logic [15:0] fetchAddress;
  logic        brownoutMode;
  logic [31:0] q;
  int          fail_count = 0;
  int          checks_done = 0;

  rbc_reset_brownout_control #(.STABLE_CYCLES(24'h000014)) dut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .externalResetPinN(externalResetPinN), .watchdogReset(watchdogReset),
    .debuggerReset(debuggerReset), .stopModeRequest(stopModeRequest),
    .stopLevelIndication(stopLevelIndication), .warnLevelOne(warnLevels[0]),
    .warnLevelTwo(warnLevels[1]), .warnLevelThree(warnLevels[2]),
    .warnLevelFour(warnLevels[3]), .detectorActive(detectorActive),
    .systemResetN(systemResetN), .initActive(initActive), .fetchEnable(fetchEnable),
    .fetchAddress(fetchAddress), .brownoutMode(brownoutMode));

  rbc_partner pm (.clk(clk), .externalResetPinN(externalResetPinN),
    .stopLevelIndication(stopLevelIndication), .warnLevels(warnLevels));

  // 20 MHz clock
  always #25 clk = ~clk;

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle; held until waitrequest is seen low at a rising edge
  task automatic access(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail_count++;
      results();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdChk(input logic [9:0] a, input logic [31:0] e);
    access(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  // Leaves time at a falling edge so outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic waitFetch();
    int n = 0;
    settle(4);
    while (fetchEnable !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) begin
      fail_count++;
      results();
    end
  endtask

  task automatic testRegs();
    pm.setWarn(4'h5);
    rdChk(10'h218, 32'h00000081);
    rdChk(10'h23C, 32'h00000005);
    access(1'b1, 10'h23C, 8'hFF);
    rdChk(10'h23C, 32'h00000005);
    pm.setWarn(4'hA);
    rdChk(10'h23C, 32'h0000000A);
    rdChk(10'h000, 32'h00000000);
    avs_byteenable <= 4'hE;
    access(1'b1, 10'h218, 8'h00);
    avs_byteenable <= 4'hF;
    rdChk(10'h218, 32'h00000081);
    access(1'b1, 10'h218, 8'h7F);
    rdChk(10'h218, 32'h00000001);
  endtask

  task automatic testPin();
    pm.pulsePin(100);
    settle(3);
    chk(fetchEnable, 32'h1);
    fork
      pm.pulsePin(200);
      begin
        settle(190);
        chk(systemResetN, 32'h0);
      end
    join
    waitFetch();
    rdChk(10'h218, 32'h00000041);
  endtask

  // Watchdog then debugger; then clear the pin flag alone
  task automatic testCpu();
    @(posedge clk);
    watchdogReset <= 1'b1;
    @(posedge clk);
    watchdogReset <= 1'b0;
    waitFetch();
    rdChk(10'h218, 32'h00000061);
    @(posedge clk);
    debuggerReset <= 1'b1;
    @(posedge clk);
    debuggerReset <= 1'b0;
    waitFetch();
    rdChk(10'h218, 32'h00000071);
    access(1'b1, 10'h218, 8'hBF);
    rdChk(10'h218, 32'h00000031);
    // Debugger reset and its flag's clear land on one edge; the set must win
    fork
      access(1'b1, 10'h218, 8'hEF);
      begin
        repeat (2) @(posedge clk);
        debuggerReset <= 1'b1;
        @(posedge clk);
        debuggerReset <= 1'b0;
      end
    join
    waitFetch();
    rdChk(10'h218, 32'h00000031);
  endtask

  task automatic testDetector();
    access(1'b1, 10'h218, 8'h30);
    settle(2);
    chk(detectorActive, 32'h0);
    pm.pulseStop(200);
    settle(3);
    chk({brownoutMode, fetchEnable}, 32'h1);
    access(1'b1, 10'h218, 8'h31);
    settle(2);
    chk(detectorActive, 32'h1);
    @(posedge clk);
    stopModeRequest <= 1'b1;
    settle(4);
    chk(detectorActive, 32'h0);
    @(posedge clk);
    stopModeRequest <= 1'b0;
    settle(4);
    chk(detectorActive, 32'h1);
  endtask

  task automatic testBrownout();
    pm.pulseStop(100);
    settle(3);
    chk({brownoutMode, fetchEnable}, 32'h1);
    fork
      pm.pulseStop(200);
      begin
        settle(170);
        chk({brownoutMode, systemResetN}, 32'h3);
      end
    join
    settle(3);
    chk({brownoutMode, systemResetN}, 32'h0);
    waitFetch();
    rdChk(10'h218, 32'h00000039);
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h00000000;
    watchdogReset = 1'b0;
    debuggerReset = 1'b0;
    stopModeRequest = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    waitFetch();
    testRegs();
    testPin();
    testCpu();
    testDetector();
    testBrownout();
    results();
  end
endmodule

`default_nettype wire
